// ==== rtl/bmsd_pkg.sv ====
// Constants and types for the boot mode strap decoder
package bmsd_pkg;

  localparam int unsigned SEL_W       = 4;
  localparam int unsigned AEM_W       = 3;
  localparam int unsigned PLLMS_W     = 3;
  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned ERR_W       = 4;
  localparam int unsigned MULT_W      = 6;
  localparam int unsigned DIV_W       = 3;
  localparam int unsigned CFG_W       = 12;

  // Boot select encodings
  localparam logic [3:0] SEL_EMUL     = 4'h0;
  localparam logic [3:0] SEL_HOST     = 4'h2;
  localparam logic [3:0] SEL_EXTROM   = 4'h4;
  localparam logic [3:0] SEL_I2C      = 4'h5;
  localparam logic [3:0] SEL_SPI16    = 4'h6;
  localparam logic [3:0] SEL_NAND     = 4'h7;
  localparam logic [3:0] SEL_UART     = 4'h8;
  localparam logic [3:0] SEL_LINK     = 4'hA;
  localparam logic [3:0] SEL_UART_FC  = 4'hE;
  localparam logic [3:0] SEL_SPI24    = 4'hF;

  // External memory mode codes
  localparam logic [2:0] AEM_FIXED    = 3'h1;
  localparam logic [2:0] AEM_USER0    = 3'h0;
  localparam logic [2:0] AEM_USER3    = 3'h3;
  localparam logic [2:0] AEM_USER4    = 3'h4;
  localparam logic [2:0] AEM_USER5    = 3'h5;

  // Start addresses
  localparam logic [31:0] ROM_LOADER_ADDR  = 32'h0010_0000;
  localparam logic [31:0] START_DEFAULT    = 32'h0010_0000;
  localparam logic [31:0] START_EXTROM     = 32'h0420_0000;

  // Clock settings of the non-fast category
  localparam logic [5:0] MULT_BYPASS  = 6'h01;
  localparam logic [2:0] DIV_ONE      = 3'h1;

  // Error codes
  localparam logic [3:0] ERR_NONE     = 4'h0;
  localparam logic [3:0] ERR_RESERVED = 4'h1;
  localparam logic [3:0] ERR_NO_I2C   = 4'h2;
  localparam logic [3:0] ERR_CATEGORY = 4'h3;

  // SPI address widths in bits
  localparam logic [4:0] SPI_ADDR16   = 5'h10;
  localparam logic [4:0] SPI_ADDR24   = 5'h18;

  // Input clock window for I2C boot, in MHz
  localparam int unsigned I2C_MIN_MHZ = 21;
  localparam int unsigned I2C_MAX_MHZ = 30;

  typedef enum logic [1:0] {
    BMSD_CAT_NONFAST = 2'b00,
    BMSD_CAT_FIXED   = 2'b01,
    BMSD_CAT_USER    = 2'b10,
    BMSD_CAT_INVALID = 2'b11
  } bmsd_cat_t;

  typedef enum logic [3:0] {
    BMSD_SRC_NONE    = 4'h0,
    BMSD_SRC_HOST    = 4'h1,
    BMSD_SRC_EXTROM  = 4'h2,
    BMSD_SRC_I2C     = 4'h3,
    BMSD_SRC_SPI     = 4'h4,
    BMSD_SRC_NAND    = 4'h5,
    BMSD_SRC_UART    = 4'h6,
    BMSD_SRC_UART_FC = 4'h7,
    BMSD_SRC_LINK    = 4'h8
  } bmsd_src_t;

  typedef enum logic [1:0] {
    BMSD_ST_RESET  = 2'b00,
    BMSD_ST_DECODE = 2'b01,
    BMSD_ST_BOOT   = 2'b10,
    BMSD_ST_DONE   = 2'b11
  } bmsd_state_t;

endpackage

// ==== rtl/bmsd_boot_mode_strap_decoder.sv ====
// Boot strap latch and boot mode decoder
// Operation
// [RQ1] Latch straps at power-on reset release
// [RQ2] Fast-start low: non-fast, PLL bypass
// [RQ3] Mode 001b: fixed multipliers, pins are width
// [RQ4] Modes 000,011,100,101: user multiplier select
// [RQ5] Invalid selection: error code, UART fallback
// [RQ6] Slave boot errors reported over UART
// [RQ7] Master modes fetch data when needed
// [RQ8] External master feeds data on demand
// [RQ9] Watchdog held disabled during boot
// [RQ10] Images must not enable watchdog during boot
// [RQ11] Non-fast: bypass, divide one, ignore multiplier
// [RQ12] 0000 emulation; 0010 host only strap low
// [RQ13] Start 0x00100000, caches off; external ROM differs
// [RQ14] Caches disabled means memories as RAM
// [RQ15] I2C boot only between 21 and 30 MHz
// [RQ16] 0110 SPI master, 16-bit address
// [RQ17] 1111 SPI master, 24-bit address, extra pin
// [RQ18] UART, UART flow, NAND, serial link codes
// [RQ19] Reserved codes are invalid
// [RQ20] Loader code starts at 0x00100000
// [RQ21] Latched configuration holds until next reset
`timescale 1ns/100ps
module bmsd_boot_mode_strap_decoder
  import bmsd_pkg::*;
#(
  parameter int unsigned CLKIN_MHZ = 25
) (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic [SEL_W-1:0]    boot_source_select,
  input  wire logic                fast_start_strap,
  input  wire logic [AEM_W-1:0]    ext_mem_mode_pins,
  input  wire logic [PLLMS_W-1:0]  pll_multiplier_select_pins,
  input  wire logic                host_bus_enable_strap,
  input  wire logic                fetch_request,
  input  wire logic                slave_data_valid,
  input  wire logic                slave_boot_error,
  input  wire logic                boot_finished,
  output logic [CFG_W-1:0]         boot_config_latch,
  output bmsd_cat_t                boot_category,
  output bmsd_src_t                boot_source,
  output logic                     boot_master,
  output logic                     pll_bypass,
  output logic                     pll_fixed_mult,
  output logic [PLLMS_W-1:0]       pll_user_select,
  output logic [AEM_W-1:0]         ext_mem_address_width_pins,
  output logic [DIV_W-1:0]         core_clk_div,
  output logic [ADDR_W-1:0]        start_vector_address,
  output logic [ADDR_W-1:0]        rom_loader_address,
  output logic [4:0]               spi_addr_bits,
  output logic                     spi_extra_gpio_line,
  output logic                     uart_flow_control,
  output logic                     cache_disable,
  output logic                     mem_all_ram,
  output logic                     watchdog_disable,
  output logic [ERR_W-1:0]         boot_completion_status,
  output logic                     uart_error_report,
  output logic                     fetch_issue,
  output logic                     wait_for_master,
  output logic                     boot_active
);

  // Straps come from pins: two-stage synchroniser first
  logic [CFG_W-1:0] strap_s1_q;
  logic [CFG_W-1:0] strap_s2_q;
  logic [CFG_W-1:0] cfg_q;
  logic             cfg_valid_q;
  bmsd_state_t      state_q;
  logic [ERR_W-1:0] err_q;
  logic             uart_err_q;
  logic             cur_fetch_q;

  always_ff @(posedge clk) begin
    strap_s1_q <= {boot_source_select, fast_start_strap, ext_mem_mode_pins,
                   pll_multiplier_select_pins, host_bus_enable_strap};
    strap_s2_q <= strap_s1_q;
  end

  // [RQ1] Latch at release
  // [RQ21] Held until reset
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_q       <= '0;
      cfg_valid_q <= 1'b0;
    end else if (!cfg_valid_q) begin
      cfg_q       <= strap_s2_q;
      cfg_valid_q <= 1'b1;
    end
  end

  logic [SEL_W-1:0]   sel;
  logic               fast;
  logic [AEM_W-1:0]   aem;
  logic [PLLMS_W-1:0] pllms;
  logic               hbus;
  assign {sel, fast, aem, pllms, hbus} = cfg_q;

  // I2C clock window evaluated at elaboration
  localparam bit I2C_OK = (CLKIN_MHZ >= I2C_MIN_MHZ) && (CLKIN_MHZ <= I2C_MAX_MHZ);

  bmsd_cat_t        cat_d;
  bmsd_src_t        src_d;
  logic             master_d;
  logic             invalid_d;
  logic [ERR_W-1:0] err_d;

  // [RQ2] Category decode
  always_comb begin
    if (!fast) begin
      cat_d = BMSD_CAT_NONFAST;
    // [RQ3] Fixed multipliers
    end else if (aem == AEM_FIXED) begin
      cat_d = BMSD_CAT_FIXED;
    // [RQ4] User multiplier
    end else if (aem == AEM_USER0 || aem == AEM_USER3 || aem == AEM_USER4 || aem == AEM_USER5) begin
      cat_d = BMSD_CAT_USER;
    end else begin
      cat_d = BMSD_CAT_INVALID;
    end
  end

  // Fast-category source tables are decoded elsewhere; only the source kind is given here
  always_comb begin
    src_d     = BMSD_SRC_UART;
    master_d  = 1'b1;
    invalid_d = 1'b0;
    err_d     = ERR_NONE;
    unique case (sel)
      // [RQ12] Emulation
      SEL_EMUL:    src_d = BMSD_SRC_NONE;
      // [RQ12] Host port strap
      SEL_HOST: begin
        if (!hbus) begin
          src_d    = BMSD_SRC_HOST;
          master_d = 1'b0;
        end else begin
          invalid_d = 1'b1;
          err_d     = ERR_RESERVED;
        end
      end
      SEL_EXTROM:  src_d = BMSD_SRC_EXTROM;
      // [RQ15] I2C clock window
      SEL_I2C: begin
        if (I2C_OK) begin
          src_d = BMSD_SRC_I2C;
        end else begin
          invalid_d = 1'b1;
          err_d     = ERR_NO_I2C;
        end
      end
      // [RQ16] [RQ17] SPI sizes
      SEL_SPI16,
      SEL_SPI24:   src_d = BMSD_SRC_SPI;
      // [RQ18] Fixed sources
      SEL_NAND:    src_d = BMSD_SRC_NAND;
      SEL_UART:    src_d = BMSD_SRC_UART;
      SEL_UART_FC: src_d = BMSD_SRC_UART_FC;
      SEL_LINK: begin
        src_d    = BMSD_SRC_LINK;
        master_d = 1'b0;
      end
      // [RQ19] Reserved codes
      default: begin
        invalid_d = 1'b1;
        err_d     = ERR_RESERVED;
      end
    endcase
    if (cat_d == BMSD_CAT_INVALID) begin
      invalid_d = 1'b1;
      err_d     = ERR_CATEGORY;
    end
    // [RQ5] Fall back to UART
    if (invalid_d) begin
      src_d    = BMSD_SRC_UART;
      master_d = 1'b1;
    end
  end

  // Boot sequence
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= BMSD_ST_RESET;
    end else begin
      unique case (state_q)
        BMSD_ST_RESET:  state_q <= cfg_valid_q ? BMSD_ST_DECODE : BMSD_ST_RESET;
        BMSD_ST_DECODE: state_q <= BMSD_ST_BOOT;
        BMSD_ST_BOOT:   state_q <= boot_finished ? BMSD_ST_DONE : BMSD_ST_BOOT;
        BMSD_ST_DONE:   state_q <= BMSD_ST_DONE;
      endcase
    end
  end

  // Decoded outputs registered once at decode
  always_ff @(posedge clk) begin
    if (srst) begin
      boot_category        <= BMSD_CAT_NONFAST;
      boot_source          <= BMSD_SRC_NONE;
      boot_master          <= 1'b1;
      pll_bypass           <= 1'b1;
      pll_fixed_mult       <= 1'b0;
      pll_user_select      <= '0;
      ext_mem_address_width_pins <= '0;
      core_clk_div         <= DIV_ONE;
      start_vector_address <= START_DEFAULT;
      spi_addr_bits        <= SPI_ADDR16;
      spi_extra_gpio_line  <= 1'b0;
      uart_flow_control    <= 1'b0;
      cache_disable        <= 1'b1;
    end else if (state_q == BMSD_ST_DECODE) begin
      boot_category        <= cat_d;
      boot_source          <= src_d;
      boot_master          <= master_d;
      // [RQ11] Bypass and divide by one
      pll_bypass           <= (cat_d == BMSD_CAT_NONFAST);
      pll_fixed_mult       <= (cat_d == BMSD_CAT_FIXED);
      // [RQ3] Pins steer address width
      ext_mem_address_width_pins <= (cat_d == BMSD_CAT_FIXED) ? pllms : '0;
      // [RQ4] User multiplier selection
      pll_user_select      <= (cat_d == BMSD_CAT_USER) ? pllms : '0;
      core_clk_div         <= DIV_ONE;
      // [RQ13] Start vector and caches
      start_vector_address <= (!invalid_d && sel == SEL_EXTROM && cat_d == BMSD_CAT_NONFAST)
                              ? START_EXTROM : START_DEFAULT;
      cache_disable        <= !(!invalid_d && sel == SEL_EXTROM && cat_d == BMSD_CAT_NONFAST);
      // [RQ16] [RQ17] SPI address width
      spi_addr_bits        <= (!invalid_d && sel == SEL_SPI24) ? SPI_ADDR24 : SPI_ADDR16;
      spi_extra_gpio_line  <= !invalid_d && sel == SEL_SPI24;
      // [RQ18] Flow control
      uart_flow_control    <= (src_d == BMSD_SRC_UART_FC);
    end
  end

  // [RQ5] Error field of completion status
  always_ff @(posedge clk) begin
    if (srst) begin
      err_q <= ERR_NONE;
    end else if (state_q == BMSD_ST_DECODE) begin
      err_q <= err_d;
    end
  end

  // [RQ6] Slave errors reported over UART; sticky until reset
  always_ff @(posedge clk) begin
    if (srst) begin
      uart_err_q <= 1'b0;
    end else if ((state_q == BMSD_ST_DECODE && invalid_d) ||
                 (state_q == BMSD_ST_BOOT && !boot_master && slave_boot_error)) begin
      uart_err_q <= 1'b1;
    end
  end

  // [RQ7] Master fetch pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      cur_fetch_q <= 1'b0;
    end else begin
      cur_fetch_q <= (state_q == BMSD_ST_BOOT) && boot_master && fetch_request;
    end
  end

  assign boot_config_latch      = cfg_q;
  assign boot_completion_status = err_q;
  assign uart_error_report      = uart_err_q;
  assign fetch_issue            = cur_fetch_q;
  assign boot_active            = (state_q != BMSD_ST_DONE);
  // [RQ8] Slave modes wait on master data
  assign wait_for_master        = (state_q == BMSD_ST_BOOT) && !boot_master && !slave_data_valid;
  // [RQ9] Watchdog off whole boot
  assign watchdog_disable       = boot_active;
  // [RQ14] Memories as RAM on exit
  assign mem_all_ram            = (state_q == BMSD_ST_DONE) && cache_disable;
  // [RQ20] Loader base
  assign rom_loader_address     = ROM_LOADER_ADDR;

  // Assertions
  // [RQ21] Config stable once latched
  AST_CFG_HOLD: assert property (@(posedge clk) disable iff (srst) // [RQ21]
    cfg_valid_q |=> $stable(cfg_q)) else $error("config changed after latch");

  // [RQ1] Latch follows synchronised straps
  // Antecedent samples srst too, so the last reset edge starts no attempt
  AST_LATCH: assert property (@(posedge clk) disable iff (srst) // [RQ1]
    !srst && !cfg_valid_q |=> cfg_q == $past(strap_s2_q)) else $error("latch missed straps");

  // [RQ2] Non-fast gives bypass
  AST_BYPASS: assert property (@(posedge clk) disable iff (srst) // [RQ2]
    state_q == BMSD_ST_BOOT && boot_category == BMSD_CAT_NONFAST |-> pll_bypass && core_clk_div == DIV_ONE)
    else $error("non-fast without bypass");

  // [RQ5] Invalid leads to UART and error
  sequence s_decode_invalid;
    state_q == BMSD_ST_DECODE && invalid_d;
  endsequence
  AST_FALLBACK: assert property (@(posedge clk) disable iff (srst) // [RQ5]
    s_decode_invalid |=> boot_source == BMSD_SRC_UART && err_q != ERR_NONE && uart_error_report)
    else $error("invalid mode without fallback");

  // [RQ9] Watchdog disabled during boot
  AST_WDOG: assert property (@(posedge clk) disable iff (srst) // [RQ9]
    state_q == BMSD_ST_BOOT |-> watchdog_disable) else $error("watchdog enabled in boot");

  // [RQ13] External ROM start vector
  AST_EXTROM: assert property (@(posedge clk) disable iff (srst) // [RQ13]
    state_q == BMSD_ST_DECODE && !invalid_d && sel == SEL_EXTROM && cat_d == BMSD_CAT_NONFAST
    |=> start_vector_address == START_EXTROM && !cache_disable) else $error("wrong external ROM vector");

  // [RQ17] 24-bit SPI uses extra line
  AST_SPI24: assert property (@(posedge clk) disable iff (srst) // [RQ17]
    spi_extra_gpio_line |-> spi_addr_bits == SPI_ADDR24) else $error("24-bit SPI mismatch");

  // [RQ8] Slave wait
  AST_WAIT: assert property (@(posedge clk) disable iff (srst) // [RQ8]
    state_q == BMSD_ST_BOOT && !boot_master && !slave_data_valid |-> wait_for_master)
    else $error("slave boot not waiting");

  // [RQ7] Fetch pulse one cycle after request
  AST_FETCH: assert property (@(posedge clk) disable iff (srst) // [RQ7]
    state_q == BMSD_ST_BOOT && boot_master && fetch_request |=> fetch_issue) else $error("fetch missed");

  // [RQ7] Slave modes never fetch
  AST_NO_SLAVE_FETCH: assert property (@(posedge clk) disable iff (srst) // [RQ7]
    !boot_master |-> !fetch_issue) else $error("fetch issued in slave mode");

  // [RQ6] Slave error reaches UART report
  AST_SLAVE_ERR: assert property (@(posedge clk) disable iff (srst) // [RQ6]
    state_q == BMSD_ST_BOOT && !boot_master && slave_boot_error |=> uart_error_report)
    else $error("slave error not reported");

  // [RQ3] Fixed multipliers, user select unused
  AST_FIXED_PINS: assert property (@(posedge clk) disable iff (srst) // [RQ3]
    boot_category == BMSD_CAT_FIXED |-> pll_user_select == '0 && !pll_bypass)
    else $error("fixed category uses user select");

  // [RQ4] User multiplier, width pins unused
  AST_USER_PINS: assert property (@(posedge clk) disable iff (srst) // [RQ4]
    boot_category == BMSD_CAT_USER |-> ext_mem_address_width_pins == '0 && !pll_fixed_mult && !pll_bypass)
    else $error("user category misconfigured");

  // [RQ14] Boot end releases watchdog, memories follow cache choice
  sequence s_boot_end;
    state_q == BMSD_ST_BOOT && boot_finished;
  endsequence
  AST_BOOT_END: assert property (@(posedge clk) disable iff (srst) // [RQ14]
    s_boot_end |=> !boot_active && !watchdog_disable && mem_all_ram == cache_disable)
    else $error("boot exit state wrong");

endmodule

// ==== verif/bmsd_far_model.sv ====
// Far-side boot master model that feeds boot data on demand
`timescale 1ns/100ps
module bmsd_far_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       wait_for_master,
  input  wire logic [3:0] feed_delay,
  input  wire logic       inject_err,
  // Boot data only, no path to the watchdog
  output logic            slave_data_valid,
  output logic            slave_boot_error
);
  logic [3:0] cnt_q;

  // Feed on demand
  // A large delay lets the bench stall the device while it waits
  always_ff @(posedge clk) begin
    if (srst || !wait_for_master) begin
      cnt_q            <= 4'h0;
      slave_data_valid <= 1'h0;
    end else if (cnt_q >= feed_delay) begin
      slave_data_valid <= 1'h1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    slave_boot_error <= !srst && inject_err;
  end
endmodule

// ==== verif/bmsd_boot_mode_strap_decoder_tb.sv ====
// Self-checking bench for the boot mode strap decoder
`timescale 1ns/100ps
module bmsd_boot_mode_strap_decoder_tb;
  import bmsd_pkg::*;
  logic              clk, srst, fast_start_strap, host_bus_enable_strap, fetch_request, boot_finished;
  logic              slave_data_valid, slave_boot_error, inject_err, boot_master, pll_bypass, pll_fixed_mult;
  logic              spi_extra_gpio_line, uart_flow_control, cache_disable, mem_all_ram, watchdog_disable;
  logic              uart_error_report, fetch_issue, wait_for_master, boot_active;
  logic [3:0]        boot_source_select, feed_delay, boot_completion_status;
  logic [2:0]        ext_mem_mode_pins, pll_multiplier_select_pins, pll_user_select, ext_mem_address_width_pins;
  logic [2:0]        core_clk_div;
  logic [4:0]        spi_addr_bits;
  logic [11:0]       boot_config_latch;
  logic [31:0]       start_vector_address, rom_loader_address;
  bmsd_cat_t         boot_category;
  bmsd_src_t         boot_source;
  int                err_count, checked, cycles;

  bmsd_boot_mode_strap_decoder u_dut (.clk, .srst, .boot_source_select, .fast_start_strap, .ext_mem_mode_pins,
    .pll_multiplier_select_pins, .host_bus_enable_strap, .fetch_request, .slave_data_valid, .slave_boot_error,
    .boot_finished, .boot_config_latch, .boot_category, .boot_source, .boot_master, .pll_bypass, .pll_fixed_mult,
    .pll_user_select, .ext_mem_address_width_pins, .core_clk_div, .start_vector_address, .rom_loader_address,
    .spi_addr_bits, .spi_extra_gpio_line, .uart_flow_control, .cache_disable, .mem_all_ram, .watchdog_disable,
    .boot_completion_status, .uart_error_report, .fetch_issue, .wait_for_master, .boot_active);

  bmsd_far_model u_far (.clk, .srst, .wait_for_master, .feed_delay, .inject_err, .slave_data_valid,
    .slave_boot_error);

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Straps settle through the synchroniser before release, then decode completes
  task automatic boot(input logic [3:0] s, input logic f, input logic [2:0] a, input logic [2:0] p, input logic h);
    @(posedge clk);
    srst                       <= 1'h1;
    boot_source_select         <= s;
    fast_start_strap           <= f;
    ext_mem_mode_pins          <= a;
    pll_multiplier_select_pins <= p;
    host_bus_enable_strap      <= h;
    fetch_request              <= 1'h0;
    boot_finished              <= 1'h0;
    inject_err                 <= 1'h0;
    repeat (4) @(posedge clk);
    srst <= 1'h0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  function automatic bmsd_src_t esrc(input logic [3:0] s, input logic h);
    case (s)
      SEL_EMUL:    return BMSD_SRC_NONE;
      SEL_HOST:    return h ? BMSD_SRC_UART : BMSD_SRC_HOST;
      SEL_EXTROM:  return BMSD_SRC_EXTROM;
      SEL_I2C:     return BMSD_SRC_I2C;
      SEL_SPI16,
      SEL_SPI24:   return BMSD_SRC_SPI;
      SEL_NAND:    return BMSD_SRC_NAND;
      SEL_LINK:    return BMSD_SRC_LINK;
      SEL_UART_FC: return BMSD_SRC_UART_FC;
      default:     return BMSD_SRC_UART;
    endcase
  endfunction

  task automatic t_reset();
    chk(boot_source, BMSD_SRC_NONE);
    chk(start_vector_address, 32'h0010_0000);
    chk(boot_completion_status, 4'h0);
    chk(watchdog_disable, 1'h1);
    chk(rom_loader_address, 32'h0010_0000);
  endtask

  // Full non-fast table, both host-bus strap levels
  task automatic t_nonfast();
    bmsd_src_t e;
    logic      v;
    logic [3:0] s;
    for (int i = 0; i < 32; i++) begin
      s = i[3:0];
      boot(s, 1'h0, 3'h0, 3'h7, i[4]);
      e = esrc(s, i[4]);
      v = (e != BMSD_SRC_UART) || (s == SEL_UART);
      chk(boot_source, e);
      chk(boot_master, (e != BMSD_SRC_HOST) && (e != BMSD_SRC_LINK));
      chk(boot_completion_status, v ? 4'h0 : 4'h1);
      chk(uart_error_report, !v);
      chk(boot_category, BMSD_CAT_NONFAST);
      chk(pll_bypass, 1'h1);
      chk(core_clk_div, 3'h1);
      chk(pll_user_select, 3'h0);
      chk(pll_fixed_mult, 1'h0);
      chk(spi_extra_gpio_line, s == 4'hF);
      chk(uart_flow_control, s == 4'hE);
      if (v) begin
        chk(start_vector_address, (s == 4'h4) ? 32'h0420_0000 : 32'h0010_0000);
        chk(cache_disable, s != 4'h4);
      end
      if (e == BMSD_SRC_SPI) begin
        chk(spi_addr_bits, (s == 4'hF) ? 5'h18 : 5'h10);
      end
    end
  endtask

  task automatic t_fast();
    for (int a = 0; a < 8; a++) begin
      boot(SEL_SPI16, 1'h1, a[2:0], 3'h5, 1'h0);
      if (a == 1) begin
        chk(boot_category, BMSD_CAT_FIXED);
        chk(pll_fixed_mult, 1'h1);
        chk(pll_bypass, 1'h0);
        chk(ext_mem_address_width_pins, 3'h5);
        chk(pll_user_select, 3'h0);
      end else if (a == 0 || a == 3 || a == 4 || a == 5) begin
        chk(boot_category, BMSD_CAT_USER);
        chk(pll_fixed_mult, 1'h0);
        chk(pll_user_select, 3'h5);
        chk(ext_mem_address_width_pins, 3'h0);
        chk(pll_bypass, 1'h0);
      end else begin
        chk(boot_completion_status, 4'h3);
        chk(boot_source, BMSD_SRC_UART);
        chk(uart_error_report, 1'h1);
      end
    end
  endtask

  task automatic t_latch();
    boot(SEL_NAND, 1'h0, 3'h3, 3'h6, 1'h1);
    @(posedge clk);
    boot_source_select         <= SEL_UART;
    fast_start_strap           <= 1'h1;
    ext_mem_mode_pins          <= 3'h1;
    pll_multiplier_select_pins <= 3'h1;
    host_bus_enable_strap      <= 1'h0;
    repeat (8) @(posedge clk);
    #1;
    chk(boot_config_latch, {4'h7, 1'h0, 3'h3, 3'h6, 1'h1});
    chk(boot_source, BMSD_SRC_NAND);
    chk(boot_category, BMSD_CAT_NONFAST);
  endtask

  task automatic t_master();
    boot(SEL_SPI24, 1'h0, 3'h0, 3'h0, 1'h0);
    @(posedge clk);
    fetch_request <= 1'h1;
    @(posedge clk);
    fetch_request <= 1'h0;
    #1;
    chk(fetch_issue, 1'h1);
    @(posedge clk);
    #1;
    chk(fetch_issue, 1'h0);
    chk(mem_all_ram, 1'h0);
    @(posedge clk);
    boot_finished <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    chk(boot_active, 1'h0);
    chk(mem_all_ram, 1'h1);
    chk(watchdog_disable, 1'h0);
  endtask

  // Slave boot stalls on a slow master, then reports its error
  task automatic t_slave();
    int n;
    n = 0;
    @(posedge clk);
    feed_delay <= 4'hF;
    boot(SEL_HOST, 1'h0, 3'h0, 3'h0, 1'h0);
    @(posedge clk);
    fetch_request <= 1'h1;
    repeat (10) begin
      @(posedge clk);
      #1;
      if (wait_for_master === 1'h1) begin
        n++;
      end
      chk(fetch_issue, 1'h0);
    end
    chk(n > 0, 1'h1);
    // Data arrives after the feed delay and the wait drops
    n = 0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (wait_for_master === 1'h0) begin
        n++;
      end
    end
    chk(n > 0, 1'h1);
    chk(uart_error_report, 1'h0);
    @(posedge clk);
    fetch_request <= 1'h0;
    inject_err    <= 1'h1;
    repeat (3) @(posedge clk);
    #1;
    chk(uart_error_report, 1'h1);
    @(posedge clk);
    feed_delay <= 4'h0;
  endtask

  initial begin
    err_count                  = 0;
    checked                    = 0;
    cycles                     = 0;
    srst                       = 1'h1;
    boot_source_select         = 4'h0;
    fast_start_strap           = 1'h0;
    ext_mem_mode_pins          = 3'h0;
    pll_multiplier_select_pins = 3'h0;
    host_bus_enable_strap      = 1'h0;
    fetch_request              = 1'h0;
    boot_finished              = 1'h0;
    inject_err                 = 1'h0;
    feed_delay                 = 4'h0;
    repeat (16) @(posedge clk);
    #1;
    t_reset();
    t_nonfast();
    t_fast();
    t_latch();
    t_master();
    t_slave();
    conclude();
  end
endmodule
